// File: verilog/cmp_cap_regs.svh
`ifndef CMP_CAP_REGS_SVH
`define CMP_CAP_REGS_SVH
`define OFS_COMPARE_A    6'h20
`define OFS_COMPARE_B    6'h24
`define OFS_CAPTURE_A    6'h28
`define OFS_CAPTURE_B    6'h2c
`define OFS_PSW_CTRL     6'h30
`define OFS_RUN_CTRL     6'h04
`define OFS_MODE_CTRL    6'h00
`define OFS_STATUS       6'h38
`define CTL_IDIS_BIT     10
`define CTL_PRD_LSB      8
`define CTL_SNGL_BIT     6
`define CTL_STP_LSB      4
`define CTL_STA_LSB      2
`define CTL_CLK_LSB      0
`define CTL_WMASK        32'h0000077f
`define RUN_BIT          0
`define MODE_BIT         0
`define CTL_RESET        32'h00000000
`endif

// File: verilog/cmp_cap_pkg.sv
package cmp_cap_pkg;
  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_RUN      = 2'b01,
    ST_STOPPING = 2'b10
  } run_state_e;

  typedef struct packed {
    logic [15:0] compare_field_a;
    logic [15:0] compare_field_b;
    logic [15:0] capture_field_a;
    logic [15:0] capture_field_b;
    logic [31:0] ctrl;
    logic        count_run_bit;
    logic        igbt_mode;
    run_state_e  state;
    logic [15:0] live_up_counter;
    logic [3:0]  prescaler;
    logic [1:0]  cycle_cnt;
    logic [31:0] rdata;
    logic        match_event_a;
    logic        match_event_b;
    logic        capture_event_a;
    logic        capture_event_b;
    logic        cycle_irq;
    logic        cmd_start_irq;
    logic        timer_toggle_output;
    logic        drive_output_a;
  } state_s;
endpackage

// File: verilog/timer_compare_capture.sv
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "cmp_cap_regs.svh"
// Behaviour
// - timer mode: counter equals compare a gives match event a, toggles output
// - timer mode: counter equals compare b gives match event b, toggles output
// - igbt mode: counter equals compare a drives output a active
// - igbt mode: counter equals compare b returns output a inactive
// - capture registers hold latched 16-bit counter copy, upper half zero
// - stopped timer keeps captures; live counter is not readable
// - control bit 10 set suppresses the command-start interrupt
// - bits 9-8 give cycle interrupt every 1, 2 or 4 cycles
// - control bit 6 selects continuous (0) or single (1) operation
// - stop style: clear and reset outputs, clear and hold, or stop at cycle end
// - bits 3-2 select command/trigger capture, command/trigger start, trigger start
// - bits 1-0 pick tick source from prescaler taps 0, 1, 2, 4
// - run bit 0 stops and clears the counter, 1 starts counting
// - capture event raised when a value is latched into a capture register
module timer_compare_capture
  import cmp_cap_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // register port
  input  wire logic [5:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // external trigger, level synchronous to core_clk
  input  wire logic        trigger_in,
  // events
  output logic             match_event_a,
  output logic             match_event_b,
  output logic             capture_event_a,
  output logic             capture_event_b,
  output logic             cycle_irq,
  output logic             cmd_start_irq,
  // pins
  output logic             timer_toggle_output,
  output logic             drive_output_a
);

  state_s q, d;
  logic   trig_q;
  logic   trig_rise;
  logic   tick;
  logic   at_a;
  logic   at_b;
  logic   [1:0] prd;
  logic   [1:0] stp;
  logic   [1:0] sta;
  logic   [1:0] clk_sel;

  assign prd       = q.ctrl[`CTL_PRD_LSB +: 2];
  assign stp       = q.ctrl[`CTL_STP_LSB +: 2];
  assign sta       = q.ctrl[`CTL_STA_LSB +: 2];
  assign clk_sel   = q.ctrl[`CTL_CLK_LSB +: 2];
  assign trig_rise = trigger_in & ~trig_q;

  // tap n is a pulse every 2^n core cycles; code 11 selects tap 4
  always_comb begin
    unique case (clk_sel)
      2'b00: tick = 1'b1;
      2'b01: tick = q.prescaler[0];
      2'b10: tick = &q.prescaler[1:0];
      2'b11: tick = &q.prescaler[3:0];
    endcase
  end

  logic [15:0] cmp_val [2];
  logic [1:0]  at_cmp;

  assign cmp_val[0] = q.compare_field_a;
  assign cmp_val[1] = q.compare_field_b;

  // one equality comparator per compare register, only looked at on a tick
  for (genvar g = 0; g < 2; g++) begin : g_cmp
    assign at_cmp[g] = tick && (q.live_up_counter == cmp_val[g]);
  end

  assign at_a = at_cmp[0];
  assign at_b = at_cmp[1];

  always_comb begin
    d = q;
    d.match_event_a   = 1'b0;
    d.match_event_b   = 1'b0;
    d.capture_event_a = 1'b0;
    d.capture_event_b = 1'b0;
    d.cycle_irq       = 1'b0;
    d.cmd_start_irq   = 1'b0;
    d.rdata           = 32'h00000000;

    // register writes
    if (wr) begin
      unique case (addr)
        `OFS_COMPARE_A: d.compare_field_a = wdata[15:0];
        `OFS_COMPARE_B: d.compare_field_b = wdata[15:0];
        // locked while running so a running cycle keeps its control settings; compare registers stay writable
        `OFS_PSW_CTRL:  if (q.state == ST_IDLE) begin
          d.ctrl = wdata & `CTL_WMASK;
          if (wdata[`CTL_PRD_LSB +: 2] == 2'b11) begin
            d.ctrl[`CTL_PRD_LSB +: 2] = 2'b00;
          end
        end
        `OFS_MODE_CTRL: if (q.state == ST_IDLE) begin
          d.igbt_mode = wdata[`MODE_BIT];
        end
        `OFS_RUN_CTRL:  d.count_run_bit = wdata[`RUN_BIT];
        default: ;
      endcase
    end

    // register reads, answered in the following cycle
    if (rd) begin
      unique case (addr)
        `OFS_COMPARE_A: d.rdata = {16'h0000, q.compare_field_a};
        `OFS_COMPARE_B: d.rdata = {16'h0000, q.compare_field_b};
        `OFS_CAPTURE_A: d.rdata = {16'h0000, q.capture_field_a};
        `OFS_CAPTURE_B: d.rdata = {16'h0000, q.capture_field_b};
        `OFS_PSW_CTRL:  d.rdata = q.ctrl;
        `OFS_MODE_CTRL: d.rdata = {31'h00000000, q.igbt_mode};
        `OFS_RUN_CTRL:  d.rdata = {31'h00000000, q.count_run_bit};
        `OFS_STATUS:    d.rdata = {31'h00000000, q.state != ST_IDLE};
        default:        d.rdata = 32'h00000000;
      endcase
    end

    unique case (q.state)
      ST_IDLE: begin
        d.prescaler       = 4'h0;
        d.live_up_counter = 16'h0000;
        if (q.count_run_bit) begin
          // trigger start mode (code 10) waits for the trigger edge
          if (sta == 2'b10) begin
            if (trig_rise) begin
              d.state = ST_RUN;
            end
          end else begin
            d.state = ST_RUN;
            d.cmd_start_irq = ~q.ctrl[`CTL_IDIS_BIT];
          end
        end
      end
      ST_RUN, ST_STOPPING: begin
        d.prescaler = q.prescaler + 4'h1;
        if (tick) begin
          d.live_up_counter = q.live_up_counter + 16'h0001;
        end
        if (at_a) begin
          if (q.igbt_mode) begin
            d.drive_output_a = 1'b1;
          end else begin
            d.match_event_a       = 1'b1;
            d.timer_toggle_output = ~q.timer_toggle_output;
          end
        end
        // compare b closes the cycle
        if (at_b) begin
          if (q.igbt_mode) begin
            d.drive_output_a = 1'b0;
          end else begin
            d.match_event_b       = 1'b1;
            d.timer_toggle_output = ~q.timer_toggle_output;
          end
          d.live_up_counter = 16'h0000;
          d.cycle_cnt       = q.cycle_cnt + 2'b01;
          unique case (prd)
            2'b00: d.cycle_irq = 1'b1;
            2'b01: d.cycle_irq = q.cycle_cnt[0];
            default: d.cycle_irq = &q.cycle_cnt;
          endcase
          if (q.ctrl[`CTL_SNGL_BIT] || q.state == ST_STOPPING) begin
            d.state           = ST_IDLE;
            // a run write landing in the same cycle wins over the automatic clear
            d.count_run_bit   = wr && (addr == `OFS_RUN_CTRL) && wdata[`RUN_BIT];
            d.cycle_cnt       = 2'b00;
            d.cycle_irq       = 1'b1;
          end
        end
        // trigger capture: command start with trigger capture latches the counter
        if (trig_rise && sta == 2'b00) begin
          d.capture_field_a = q.live_up_counter;
          d.capture_event_a = 1'b1;
        end
        // command start with trigger start: a trigger restarts the cycle
        if (trig_rise && sta == 2'b01) begin
          d.capture_field_b = q.live_up_counter;
          d.capture_event_b = 1'b1;
          d.live_up_counter = 16'h0000;
        end
        if (!q.count_run_bit && q.state == ST_RUN) begin
          if (stp == 2'b10) begin
            d.state = ST_STOPPING;
          end else begin
            d.state           = ST_IDLE;
            d.live_up_counter = 16'h0000;
            d.cycle_cnt       = 2'b00;
            if (stp == 2'b00) begin
              d.drive_output_a      = 1'b0;
              d.timer_toggle_output = 1'b0;
            end
          end
        end
      end
      default: d.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      q      <= '0;
      trig_q <= 1'b0;
    end else begin
      q      <= d;
      trig_q <= trigger_in;
    end
  end

  assign rdata               = q.rdata;
  assign match_event_a       = q.match_event_a;
  assign match_event_b       = q.match_event_b;
  assign capture_event_a     = q.capture_event_a;
  assign capture_event_b     = q.capture_event_b;
  assign cycle_irq           = q.cycle_irq;
  assign cmd_start_irq       = q.cmd_start_irq;
  assign timer_toggle_output = q.timer_toggle_output;
  assign drive_output_a      = q.drive_output_a;

endmodule

// File: testbench/trig_src.sv
`timescale 1ns/1ps
// far-side trigger source: idle low, one rising edge per request
module trig_src (
  // clock and request
  input  wire logic core_clk,
  input  wire logic fire,
  // trigger pin
  output logic      trigger_in
);
  initial trigger_in = 1'b0;
  always @(posedge core_clk) trigger_in <= fire;
endmodule

// File: testbench/tcc_chk.sv
`timescale 1ns/1ps
module tcc_chk (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [5:0]  addr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        match_event_a,
  input wire logic        match_event_b,
  input wire logic        capture_event_a,
  input wire logic        cmd_start_irq,
  input wire logic        drive_output_a
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data not idle");
  AST_CAP_HI: assert property ($past(rd) && $past(addr[5:3]) == 3'h5 |-> rdata[31:16] == 16'h0)
    else $error("capture upper half set");
  AST_RST_OUT: assert property (disable iff (1'b0) $past(rst) |-> !drive_output_a && !match_event_a)
    else $error("output active after reset");
  AST_MA_PULSE: assert property (match_event_a |=> !match_event_a)
    else $error("match a too long");
  AST_MB_PULSE: assert property (match_event_b |=> !match_event_b)
    else $error("match b too long");
  AST_MATCH_EXCL: assert property (!(match_event_a && match_event_b))
    else $error("matches together");
  AST_CAP_PULSE: assert property (capture_event_a |=> !capture_event_a)
    else $error("capture event too long");
  AST_CMD_PULSE: assert property (cmd_start_irq |=> !cmd_start_irq)
    else $error("start irq too long");
  cover property (match_event_b);
  cover property (capture_event_a);
  cover property ($fell(drive_output_a));
endmodule
bind timer_compare_capture tcc_chk chk (.core_clk, .rst, .addr, .rd, .rdata, .match_event_a,
  .match_event_b, .capture_event_a, .cmd_start_irq, .drive_output_a);

// File: testbench/tb.sv
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, fire = 1'b0, trigger_in;
  logic [5:0]  addr = 6'h0;
  logic [31:0] wdata = 32'h0, rdata, d, e;
  logic ma, mb, ca, cb, cyc, cmd, tog, drv;
  int fails = 0, compares = 0, cycles = 0, n;
  timer_compare_capture uut (.core_clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .trigger_in,
    .match_event_a(ma), .match_event_b(mb), .capture_event_a(ca), .capture_event_b(cb),
    .cycle_irq(cyc), .cmd_start_irq(cmd), .timer_toggle_output(tog), .drive_output_a(drv));
  trig_src far (.core_clk, .fire, .trigger_in);
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (++cycles == 20000) begin fails++; wrap_up(); end
  task automatic chk(string nm, logic [31:0] s, logic [31:0] x);
    compares++;
    if (s !== x) begin
      fails++;
      $display("ERROR %s exp %h got %h", nm, x, s);
    end
  endtask
  // word accesses only
  task automatic wr_reg(logic [5:0] a, logic [31:0] v);
    @(posedge core_clk); addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge core_clk); wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [5:0] a, output logic [31:0] v);
    @(posedge core_clk); addr <= a; rd <= 1'b1;
    @(posedge core_clk); rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic wait_ev(ref logic ev, input logic lvl, input int lim, output int k);
    k = 0;
    while (ev !== lvl && k < lim) begin @(posedge core_clk); #1 k++; end
  endtask
  task automatic pulse_trig;
    @(posedge core_clk) fire <= 1'b1;
    @(posedge core_clk) fire <= 1'b0;
  endtask
  task automatic count_ev(ref logic ev, input int lim, output int k);
    k = 0;
    repeat (lim) begin @(posedge core_clk); #1 if (ev === 1'b1) k++; end
  endtask
  task automatic t_reset;
    logic [5:0] ofs [9] = '{6'h20, 6'h24, 6'h28, 6'h2c, 6'h30, 6'h00, 6'h04, 6'h38, 6'h3c};
    foreach (ofs[i]) begin
      rd_reg(ofs[i], d);
      chk("reset value", d, 32'h0);
    end
    wr_reg(6'h30, 32'hffffffff);
    rd_reg(6'h30, d);
    chk("ctrl mask", d, 32'h0000047f);
  endtask
  task automatic t_taps;
    for (int c = 0; c < 4; c++) begin
      wr_reg(6'h30, c | ((c == 3) ? 32'h400 : 32'h0));
      wr_reg(6'h20, 32'h4);
      wr_reg(6'h24, 32'h8);
      wr_reg(6'h04, 32'h1);
      wait_ev(cmd, 1'b1, 8, n);
      chk("start irq", n < 8, c != 3);
      wait_ev(ma, 1'b1, 300, n);
      wait_ev(mb, 1'b1, 300, n);
      chk("match span", n, 4 * ((c == 3) ? 16 : (1 << c)));
      wr_reg(6'h04, 32'h0);
    end
  endtask
  task automatic t_capture;
    wr_reg(6'h30, 32'h0);
    wr_reg(6'h04, 32'h1);
    wait_ev(ma, 1'b1, 50, n);
    pulse_trig();
    wait_ev(ca, 1'b1, 6, n);
    chk("capture event", n < 6, 1'b1);
    rd_reg(6'h28, d);
    chk("capture range", d <= 32'h8, 1'b1);
    wr_reg(6'h04, 32'h0);
    rd_reg(6'h28, e);
    chk("capture held", e, d);
  endtask
  task automatic t_modes;
    logic t;
    for (int p = 0; p < 3; p++) begin
      wr_reg(6'h30, p << 8);
      wr_reg(6'h04, 32'h1);
      wait_ev(mb, 1'b1, 50, n);
      t = tog;
      wait_ev(ma, 1'b1, 50, n);
      chk("toggle a", tog, !t);
      wait_ev(mb, 1'b1, 50, n);
      chk("toggle b", tog, t);
      count_ev(cyc, 36, n);
      chk("cycle irq count", n, 4 >> p);
      wr_reg(6'h04, 32'h0);
    end
    wr_reg(6'h30, 32'h40);
    wr_reg(6'h04, 32'h1);
    wait_ev(mb, 1'b1, 50, n);
    chk("single end irq", cyc, 1'b1);
    rd_reg(6'h38, d);
    chk("single stopped", d, 32'h0);
    rd_reg(6'h04, d);
    chk("single run bit", d, 32'h0);
    wr_reg(6'h30, 32'h20);
    wr_reg(6'h04, 32'h1);
    wait_ev(ma, 1'b1, 50, n);
    wr_reg(6'h04, 32'h0);
    rd_reg(6'h38, d);
    chk("deferred stop running", d, 32'h1);
    wait_ev(cyc, 1'b1, 50, n);
    chk("deferred stop irq", n < 50, 1'b1);
    rd_reg(6'h38, d);
    chk("deferred stop done", d, 32'h0);
    wr_reg(6'h30, 32'h4);
    wr_reg(6'h04, 32'h1);
    wait_ev(ma, 1'b1, 50, n);
    pulse_trig();
    wait_ev(cb, 1'b1, 6, n);
    chk("capture b event", n < 6, 1'b1);
    rd_reg(6'h2c, d);
    chk("capture b range", d > 32'h4 && d <= 32'h8, 1'b1);
    wr_reg(6'h04, 32'h0);
    wr_reg(6'h30, 32'h8);
    wr_reg(6'h04, 32'h1);
    rd_reg(6'h38, d);
    chk("wait for trigger", d, 32'h0);
    pulse_trig();
    rd_reg(6'h38, d);
    chk("trigger started", d, 32'h1);
    wr_reg(6'h04, 32'h0);
  endtask
  task automatic t_igbt;
    wr_reg(6'h00, 32'h1);
    for (int s = 0; s < 2; s++) begin
      wr_reg(6'h30, s << 4);
      wr_reg(6'h04, 32'h1);
      wait_ev(drv, 1'b1, 50, n);
      chk("drive on", drv, 1'b1);
      wait_ev(drv, 1'b0, 50, n);
      chk("drive span", n, 4);
      wait_ev(drv, 1'b1, 50, n);
      wr_reg(6'h04, 32'h0);
      repeat (2) @(posedge core_clk);
      #1 chk("drive at stop", drv, s);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_taps();
    t_capture();
    t_modes();
    t_igbt();
    wrap_up();
  end
endmodule
